// [src/psq_sequencer.sv]
// Purpose: instruction sequencing, return stack, table reads and data map of a small controller
// Assumes: program memory answers within one instruction cycle; data sampled at the last phase
// Notes: flag logic, watchdog, halt and pin behaviour live elsewhere
`timescale 1ns/1ps
`include "psq_defines.svh"

// Operation
// RULE1 - system clock split into four phases per instruction cycle
// RULE2 - fetch next word while current one executes, one instruction per cycle
// RULE3 - program counter changes cost a dummy cycle replacing the prefetched word
// RULE4 - program counter is ten bits, 1024 addresses
// RULE5 - program counter increments by one after each fetch
// RULE6 - taken skip discards prefetch, inserts dummy, continues at address plus two
// RULE7 - write to counter low byte replaces bits 7..0, keeps 9..8
// RULE8 - reset clears program counter, start at 000H
// RULE9 - jump and call load ten bits from code, return from stack
// RULE10 - call pushes program counter, return restores it
// RULE11 - single hidden stack entry, newest call overwrites it
// RULE12 - stack index points to top after reset
// RULE13 - program memory 1024 by 14, addressed by counter or table pointer
// RULE14 - current-page table address uses counter bits 9..8 and pointer
// RULE15 - last-page table address forces bits 9..8 high
// RULE16 - table read low byte to data, upper six bits to table high
// RULE17 - table high register is read only
// RULE18 - software loads table pointer before a table read
// RULE19 - table read takes two instruction cycles
// RULE20 - unimplemented locations below 20H read 00H
// RULE21 - general data memory at 20H..3FH
// RULE22 - decode pointer 01H, working 05H, status 0AH, ports 12H/14H/16H
// RULE23 - single bits settable and clearable except dedicated bits
// RULE24 - location 00H accesses location addressed by memory pointer
module psq_sequencer #(
   parameter int PMEM_DEPTH = `PSQ_PMEM_DEPTH
)(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic [`PSQ_IW-1:0] pmem_data_in,
   output logic [`PSQ_PC_W-1:0] pmem_addr_out,
   output logic [3:0] phase_out,
   output logic [`PSQ_PC_W-1:0] program_counter_out,
   output logic [7:0] working_register_out,
   output psq_pkg::psq_ports_t port_data_out
);
   import psq_pkg::*;

   // elaboration check: the counter cannot address any other depth
   if (PMEM_DEPTH != (1 << `PSQ_PC_W))
   begin
      $error("program memory depth must match the counter width");
   end

   psq_state_t state_q;
   psq_state_t state_d;
   psq_op_t op_w;
   logic end_cyc_w;
   logic wr_en_w;
   logic [5:0] wr_addr_w;
   logic [7:0] wr_val_w;
   logic [7:0] rd_val_w;
   logic skip_take_w;
   logic low_byte_wr_w;

   // ----------------------------------------
   // decode and data map
   // ----------------------------------------
   function automatic psq_op_t decode(input logic [`PSQ_IW-1:0] w);
      psq_op_t o;
      o = OP_NOP;
      if (w[13:12] == `PSQ_CLS_JUMP)
         o = OP_JUMP;
      else if (w[13:12] == `PSQ_CLS_CALL)
         o = OP_CALL;
      else if (w[13:12] == `PSQ_CLS_BIT)
         o = w[11] ? OP_BITSET : OP_BITCLR;
      else
      begin
         case (w[11:8])
            `PSQ_SUB_RETURN: o = OP_RETURN;
            `PSQ_SUB_TABC: o = OP_TAB_CUR;
            `PSQ_SUB_TABL: o = OP_TAB_LAST;
            `PSQ_SUB_STORE: o = OP_STORE;
            `PSQ_SUB_LOAD: o = OP_LOAD;
            `PSQ_SUB_LOADI: o = OP_LOADI;
            `PSQ_SUB_SKIPZ: o = OP_SKIPZ;
            default: o = OP_NOP;
         endcase
      end
      return o;
   endfunction

   // RULE24 indirect resolve
   function automatic logic [5:0] eff_addr(input logic [5:0] a);
      return (a == `PSQ_A_INDIRECT) ? state_q.memory_pointer : a;
   endfunction

   function automatic logic [7:0] rd_loc(input logic [5:0] a);
      logic [7:0] v;
      v = 8'h00;
      // RULE21 general data memory
      if (a >= `PSQ_A_RAM_BASE)
         v = state_q.ram[a[4:0]];
      // RULE22 special register decode
      else if (a == `PSQ_A_MEMPTR)
         v = {`PSQ_MEMPTR_FILL, state_q.memory_pointer};
      else if (a == `PSQ_A_WORK)
         v = state_q.working_register;
      else if (a == `PSQ_A_CLOW)
         v = state_q.program_counter[7:0];
      else if (a == `PSQ_A_TPTR)
         v = state_q.table_pointer;
      else if (a == `PSQ_A_THIGH)
         v = {2'h0, state_q.table_high_byte};
      else if (a == `PSQ_A_STATUS)
         v = {2'h0, state_q.status_flags};
      else if (a == `PSQ_A_PORTA)
         v = state_q.ports.port_a_data;
      else if (a == `PSQ_A_PORTB)
         v = state_q.ports.port_b_data;
      else if (a == `PSQ_A_PORTC)
         v = state_q.ports.port_c_data;
      // RULE20 reserved reads zero
      else
         v = 8'h00;
      return v;
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      state_d = state_q;
      op_w = decode(state_q.instr);
      end_cyc_w = (state_q.phase == `PSQ_PH_LAST);
      rd_val_w = rd_loc(eff_addr(state_q.instr[5:0]));
      wr_en_w = 1'b0;
      wr_addr_w = eff_addr(state_q.instr[5:0]);
      wr_val_w = 8'h00;
      skip_take_w = 1'b0;
      low_byte_wr_w = 1'b0;

      // RULE1 four phase counter
      state_d.phase = state_q.phase + 2'h1;
      state_d.phase_hot = 4'h1 << state_d.phase;

      if (end_cyc_w)
      begin
         if (state_q.tab_pend)
         begin
            // RULE16 table word split
            wr_en_w = 1'b1;
            wr_addr_w = state_q.tab_dst;
            wr_val_w = pmem_data_in[7:0];
            state_d.table_high_byte = pmem_data_in[13:8];
            state_d.tab_pend = 1'b0;
         end
         else
         begin
            // RULE2 prefetched word enters execute
            state_d.instr = pmem_data_in;
            state_d.instr_valid = 1'b1;
            // RULE5 increment after fetch
            state_d.program_counter = state_q.program_counter + 10'h001;
            if (state_q.instr_valid)
            begin
               case (op_w)
                  OP_JUMP:
                  begin
                     // RULE9 load from code
                     state_d.program_counter = state_q.instr[9:0];
                     // RULE3 dummy replaces prefetch
                     state_d.instr_valid = 1'b0;
                  end
                  OP_CALL:
                  begin
                     // RULE10 push return address
                     // RULE11 newest call overwrites entry
                     state_d.stack_entry = state_q.program_counter;
                     state_d.stack_full = 1'b1;
                     state_d.program_counter = state_q.instr[9:0];
                     state_d.instr_valid = 1'b0;
                  end
                  OP_RETURN:
                  begin
                     // RULE9 load from stack
                     state_d.program_counter = state_q.stack_entry;
                     state_d.stack_full = 1'b0;
                     state_d.instr_valid = 1'b0;
                  end
                  OP_TAB_CUR:
                  begin
                     // RULE14 current page address
                     // RULE18 pointer loaded beforehand by software
                     state_d.tab_addr = {state_q.program_counter[9:8], state_q.table_pointer};
                     state_d.tab_dst = wr_addr_w;
                     // RULE19 second cycle reads the table
                     state_d.tab_pend = 1'b1;
                  end
                  OP_TAB_LAST:
                  begin
                     // RULE15 last page address
                     state_d.tab_addr = {`PSQ_LAST_PAGE, state_q.table_pointer};
                     state_d.tab_dst = wr_addr_w;
                     state_d.tab_pend = 1'b1;
                  end
                  OP_STORE:
                  begin
                     wr_en_w = 1'b1;
                     wr_val_w = state_q.working_register;
                  end
                  OP_LOAD:
                     state_d.working_register = rd_val_w;
                  OP_LOADI:
                     state_d.working_register = state_q.instr[7:0];
                  OP_SKIPZ:
                  begin
                     // RULE6 counter already one past prefetch
                     skip_take_w = (rd_val_w == 8'h00);
                     if (skip_take_w)
                        state_d.instr_valid = 1'b0;
                  end
                  OP_BITSET:
                  begin
                     // RULE23 single bit set
                     wr_en_w = 1'b1;
                     wr_val_w = rd_val_w | (8'h01 << state_q.instr[10:8]);
                  end
                  OP_BITCLR:
                  begin
                     // RULE23 single bit clear
                     wr_en_w = 1'b1;
                     wr_val_w = rd_val_w & ~(8'h01 << state_q.instr[10:8]);
                  end
                  default:
                     state_d.instr_valid = 1'b1;
               endcase
            end
         end

         // write path; location 00H with pointer 00H writes nothing
         if (wr_en_w)
         begin
            if (wr_addr_w >= `PSQ_A_RAM_BASE)
               state_d.ram[wr_addr_w[4:0]] = wr_val_w;
            else if (wr_addr_w == `PSQ_A_MEMPTR)
               state_d.memory_pointer = wr_val_w[5:0];
            else if (wr_addr_w == `PSQ_A_WORK)
               state_d.working_register = wr_val_w;
            else if (wr_addr_w == `PSQ_A_CLOW)
               low_byte_wr_w = 1'b1;
            else if (wr_addr_w == `PSQ_A_TPTR)
               state_d.table_pointer = wr_val_w;
            // RULE23 dedicated status bits stay untouched
            else if (wr_addr_w == `PSQ_A_STATUS)
               state_d.status_flags = (state_q.status_flags & ~`PSQ_STATUS_WMASK) |
                                      (wr_val_w[5:0] & `PSQ_STATUS_WMASK);
            else if (wr_addr_w == `PSQ_A_PORTA)
               state_d.ports.port_a_data = wr_val_w;
            else if (wr_addr_w == `PSQ_A_PORTB)
               state_d.ports.port_b_data = wr_val_w;
            else if (wr_addr_w == `PSQ_A_PORTC)
               state_d.ports.port_c_data = wr_val_w;
            // RULE17 table high ignores writes; a table capture above still stands
            else if (wr_addr_w == `PSQ_A_THIGH)
               state_d.table_high_byte = state_d.table_high_byte;
         end

         if (low_byte_wr_w)
         begin
            // RULE7 short jump in page
            state_d.program_counter = {state_q.program_counter[9:8], wr_val_w};
            state_d.instr_valid = 1'b0;
         end
      end

      // RULE13 program memory address select
      state_d.pmem_addr = state_d.tab_pend ? state_d.tab_addr : state_d.program_counter;
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state_q <= '0;
         state_q.phase_hot <= `PSQ_PH_RST;
         // RULE8 start at 000H
         state_q.program_counter <= `PSQ_PC_RST;
         state_q.pmem_addr <= `PSQ_PC_RST;
         // RULE12 index at top
         state_q.stack_index <= `PSQ_SIDX_TOP;
      end
      else
         state_q <= state_d;
   end

   // RULE4 ten bit counter out
   assign program_counter_out = state_q.program_counter;
   assign pmem_addr_out = state_q.pmem_addr;
   assign phase_out = state_q.phase_hot;
   assign working_register_out = state_q.working_register;
   assign port_data_out = state_q.ports;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (sys_rst_in);

   logic exec_w;
   assign exec_w = end_cyc_w && !state_q.tab_pend && state_q.instr_valid;

   property p_phase_cycle;
      phase_out == 4'h1 |=> phase_out == 4'h2 ##1 phase_out == 4'h4 ##1 phase_out == 4'h8 ##1 phase_out == 4'h1;
   endproperty
   a_phase_cycle: assert property (p_phase_cycle) else $error("phase sequence broken"); // RULE1

   property p_pc_incr;
      exec_w && op_w == OP_NOP |=> state_q.program_counter == $past(state_q.program_counter) + 10'h001;
   endproperty
   a_pc_incr: assert property (p_pc_incr) else $error("counter did not step by one"); // RULE5

   property p_jump_dummy;
      exec_w && op_w == OP_JUMP |=> !state_q.instr_valid ##4 state_q.instr_valid;
   endproperty
   a_jump_dummy: assert property (p_jump_dummy) else $error("jump without single dummy cycle"); // RULE3

   property p_jump_target;
      exec_w && op_w == OP_JUMP |=> pmem_addr_out == $past(state_q.instr[9:0]);
   endproperty
   a_jump_target: assert property (p_jump_target) else $error("jump fetched wrong address"); // RULE9

   property p_call_push;
      exec_w && op_w == OP_CALL |=> state_q.stack_entry == $past(state_q.program_counter) && state_q.stack_full;
   endproperty
   a_call_push: assert property (p_call_push) else $error("call did not push counter"); // RULE10

   property p_skip_two;
      exec_w && skip_take_w |=> state_q.program_counter == $past(state_q.program_counter) + 10'h001
         && !state_q.instr_valid;
   endproperty
   a_skip_two: assert property (p_skip_two) else $error("skip did not land two ahead"); // RULE6

   property p_low_byte;
      end_cyc_w && low_byte_wr_w |=> state_q.program_counter ==
         {$past(state_q.program_counter[9:8]), $past(wr_val_w)};
   endproperty
   a_low_byte: assert property (p_low_byte) else $error("short jump left the page"); // RULE7

   property p_tab_last;
      exec_w && op_w == OP_TAB_LAST |=> pmem_addr_out == {`PSQ_LAST_PAGE, $past(state_q.table_pointer)};
   endproperty
   a_tab_last: assert property (p_tab_last) else $error("last page address wrong"); // RULE15

   property p_tab_two;
      exec_w && op_w == OP_TAB_CUR |=> state_q.tab_pend [*4] ##1 !state_q.tab_pend;
   endproperty
   a_tab_two: assert property (p_tab_two) else $error("table read not two cycles"); // RULE19

   property p_tab_high;
      end_cyc_w && state_q.tab_pend |=> state_q.table_high_byte == $past(pmem_data_in[13:8]);
   endproperty
   a_tab_high: assert property (p_tab_high) else $error("table high not captured"); // RULE16

   property p_reserved_zero;
      exec_w && op_w == OP_LOAD && (state_q.instr[5:0] == 6'h02 || state_q.instr[5:0] == 6'h0C)
         |=> working_register_out == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved location read nonzero"); // RULE20

   c_call: cover property (exec_w && op_w == OP_CALL);
   c_return: cover property (exec_w && op_w == OP_RETURN);
   c_tab_cur: cover property (exec_w && op_w == OP_TAB_CUR);
   c_skip: cover property (exec_w && skip_take_w);
endmodule

// [shared/psq_defines.svh]
// Purpose: constants of the program sequencer: data map, field positions, reset values, timing
// Assumes: 14-bit program words, 6-bit data addresses
// Notes: instruction encoding below is local to this sequencer
`ifndef PSQ_DEFINES_SVH
`define PSQ_DEFINES_SVH

// ----------------------------------------
// widths and timing
// ----------------------------------------
`define PSQ_PC_W 10
`define PSQ_IW 14
`define PSQ_PMEM_DEPTH 1024
`define PSQ_PHASES 4
`define PSQ_PH_LAST 2'h3
`define PSQ_PH_RST 4'h1
`define PSQ_PC_RST 10'h000
`define PSQ_SIDX_TOP 1'b0
`define PSQ_LAST_PAGE 2'h3

// ----------------------------------------
// data memory map
// ----------------------------------------
`define PSQ_A_INDIRECT 6'h00
`define PSQ_A_MEMPTR 6'h01
`define PSQ_A_WORK 6'h05
`define PSQ_A_CLOW 6'h06
`define PSQ_A_TPTR 6'h07
`define PSQ_A_THIGH 6'h08
`define PSQ_A_STATUS 6'h0A
`define PSQ_A_PORTA 6'h12
`define PSQ_A_PORTB 6'h14
`define PSQ_A_PORTC 6'h16
`define PSQ_A_RAM_BASE 6'h20
`define PSQ_MEMPTR_FILL 2'h3
`define PSQ_STATUS_WMASK 6'h0F

// ----------------------------------------
// instruction fields
// ----------------------------------------
`define PSQ_CLS_MISC 2'h0
`define PSQ_CLS_BIT 2'h1
`define PSQ_CLS_JUMP 2'h2
`define PSQ_CLS_CALL 2'h3
`define PSQ_SUB_NOP 4'h0
`define PSQ_SUB_RETURN 4'h1
`define PSQ_SUB_TABC 4'h2
`define PSQ_SUB_TABL 4'h3
`define PSQ_SUB_STORE 4'h4
`define PSQ_SUB_LOAD 4'h5
`define PSQ_SUB_LOADI 4'h6
`define PSQ_SUB_SKIPZ 4'h7

`endif

// [shared/psq_pkg.sv]
// Purpose: types of the program sequencer
// Assumes: psq_defines.svh on the include path
// Notes: the whole sequencer state is one packed struct
`include "psq_defines.svh"

package psq_pkg;

   // ----------------------------------------
   // decoded operation
   // ----------------------------------------
   typedef enum logic [3:0] {
      OP_NOP,
      OP_JUMP,
      OP_CALL,
      OP_RETURN,
      OP_TAB_CUR,
      OP_TAB_LAST,
      OP_STORE,
      OP_LOAD,
      OP_LOADI,
      OP_SKIPZ,
      OP_BITSET,
      OP_BITCLR
   } psq_op_t;

   // ----------------------------------------
   // port data registers
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] port_a_data;
      logic [7:0] port_b_data;
      logic [7:0] port_c_data;
   } psq_ports_t;

   // ----------------------------------------
   // full state
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] phase;
      logic [3:0] phase_hot;
      logic [`PSQ_PC_W-1:0] program_counter;
      logic [`PSQ_PC_W-1:0] pmem_addr;
      logic [`PSQ_PC_W-1:0] stack_entry;
      logic stack_index;
      logic stack_full;
      logic [`PSQ_IW-1:0] instr;
      logic instr_valid;
      logic tab_pend;
      logic [`PSQ_PC_W-1:0] tab_addr;
      logic [5:0] tab_dst;
      logic [5:0] memory_pointer;
      logic [7:0] working_register;
      logic [7:0] table_pointer;
      logic [5:0] table_high_byte;
      logic [5:0] status_flags;
      psq_ports_t ports;
      logic [31:0][7:0] ram;
   } psq_state_t;

endpackage

// [tb/psq_pmem_model.sv]
// Purpose: program memory partner that answers the sequencer fetch and table addresses
// Assumes: one 14-bit word per address, contents loaded by the bench through put and fill
// Notes: slow mode shows a shifting junk pattern until the third phase of each instruction cycle
`timescale 1ns/1ps
`include "psq_defines.svh"

module psq_pmem_model (
   input wire logic clk_sys_in,
   input wire logic slow_in,
   input wire logic [`PSQ_PC_W-1:0] addr_in,
   output logic [`PSQ_IW-1:0] data_out
);
   // ----------------------------------------
   // storage
   // ----------------------------------------
   // 1024 by 14
   logic [`PSQ_IW-1:0] mem [0:`PSQ_PMEM_DEPTH-1];
   logic [`PSQ_PC_W-1:0] last_addr = '0;
   int age = 0;

   // age of the current address, capped so it never wraps
   always @(posedge clk_sys_in)
   begin
      age <= (addr_in != last_addr) ? 0 : ((age < 3) ? age + 1 : age);
      last_addr <= addr_in;
   end

   // junk changes every clock so a stale sample never passes by chance
   // valid from the third phase on, so the sample at the end of the cycle sees the real word
   assign data_out = (slow_in && (addr_in != last_addr || age < 1)) ? ~mem[addr_in] ^ 14'(age) : mem[addr_in];

   task automatic fill(input logic [`PSQ_IW-1:0] w);
      for (int i = 0; i < `PSQ_PMEM_DEPTH; i++)
         mem[i] = w;
   endtask

   task automatic put(input logic [`PSQ_PC_W-1:0] a, input logic [`PSQ_IW-1:0] w);
      mem[a] = w;
   endtask
endmodule

// [tb/testbench.sv]
// Purpose: self-checking bench of the program sequencer with small programs and random data
// Assumes: program memory partner answers by the last phase; inputs change on the falling edge
// Notes: expectations come from fetch traces and final register values worked out here
`timescale 1ns/1ps
`include "psq_defines.svh"

module testbench;
   import psq_pkg::*;
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic slow = 1'b0;
   logic [`PSQ_IW-1:0] pmem_data;
   logic [`PSQ_PC_W-1:0] pmem_addr;
   logic [`PSQ_PC_W-1:0] pc;
   logic [3:0] phase;
   logic [7:0] work;
   psq_ports_t ports;
   int n_fail = 0;
   int checks = 0;
   logic [31:0] seed = 32'hC97B;

   always #50 clk_sys_in = ~clk_sys_in;

   psq_sequencer #(.PMEM_DEPTH(`PSQ_PMEM_DEPTH)) DUT (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .pmem_data_in(pmem_data),
      .pmem_addr_out(pmem_addr),
      .phase_out(phase),
      .program_counter_out(pc),
      .working_register_out(work),
      .port_data_out(ports)
   );

   psq_pmem_model pmem (
      .clk_sys_in(clk_sys_in),
      .slow_in(slow),
      .addr_in(pmem_addr),
      .data_out(pmem_data)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   function automatic logic [13:0] op_w(input logic [3:0] sub, input logic [7:0] arg);
      return {`PSQ_CLS_MISC, sub, arg};
   endfunction

   function automatic logic [13:0] br_w(input logic [1:0] cls, input logic [9:0] t);
      return {cls, 2'h0, t};
   endfunction

   function automatic logic [13:0] bit_w(input logic set, input logic [2:0] b, input logic [7:0] a);
      return {`PSQ_CLS_BIT, set, b, a};
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic next_cycle();
      int i;
      i = 0;
      @(negedge clk_sys_in);
      while (phase !== 4'h1 && i < 8)
      begin
         @(negedge clk_sys_in);
         i++;
      end
      if (i >= 8)
      begin
         n_fail++;
         $display("[FAIL] phase expected 1 seen %h", phase);
         stop_test();
      end
      check("clocks per cycle", 24'(i + 1), 24'(`PSQ_PHASES));
   endtask

   task automatic prep();
      sys_rst_in = 1'b1;
      pmem.fill(14'h0000);
   endtask

   task automatic prog(input logic [9:0] base, input logic [13:0] w[$]);
      foreach (w[k])
         pmem.put(base + 10'(k), w[k]);
   endtask

   task automatic go();
      repeat (10) @(negedge clk_sys_in);
      check("reset address", 24'(pmem_addr), 24'h0);
      check("reset counter", 24'(pc), 24'(`PSQ_PC_RST));
      check("reset phase", 24'(phase), 24'h1);
      check("reset working", 24'(work), 24'h0);
      check("reset ports", 24'(ports), 24'h0);
      sys_rst_in = 1'b0;
   endtask

   task automatic trace(input logic [9:0] seq[$]);
      foreach (seq[k])
      begin
         check("fetch address", 24'(pmem_addr), 24'(seq[k]));
         next_cycle();
      end
   endtask

   task automatic finals(input string name, input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
                         input logic [7:0] w, input logic [9:0] pcx);
      repeat (24) next_cycle();
      check("final counter", 24'(pc), 24'(pcx));
      check("port a", 24'(ports.port_a_data), 24'(a));
      check("port b", 24'(ports.port_b_data), 24'(b));
      check("port c", 24'(ports.port_c_data), 24'(c));
      check("working", 24'(work), 24'(w));
      $display("scenario %s done", name);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      logic [7:0] r1;
      logic [7:0] r2;
      logic [7:0] p;
      logic [13:0] wc;
      logic [13:0] wl;
      logic [2:0] b1;
      logic [2:0] b2;
      for (int it = 0; it < 3; it++)
      begin
         slow = it[0];
         r1 = rnd() | 8'h01;
         r2 = rnd() | 8'h02;
         b1 = 3'(rnd());
         b2 = 3'(rnd());
         p = rnd() | 8'h40;
         wc = 14'({rnd(), rnd()});
         wl = 14'({rnd(), rnd()});
         // second call overwrites the single return entry
         prep();
         prog(10'h000, '{op_w(`PSQ_SUB_LOADI, r1), br_w(`PSQ_CLS_JUMP, 10'h155)});
         prog(10'h155, '{br_w(`PSQ_CLS_CALL, 10'h2A0), br_w(`PSQ_CLS_JUMP, 10'h300)});
         prog(10'h2A0, '{br_w(`PSQ_CLS_CALL, 10'h3F0), op_w(`PSQ_SUB_LOADI, r2), op_w(`PSQ_SUB_STORE, 8'h12)});
         prog(10'h3F0, '{op_w(`PSQ_SUB_STORE, 8'h14), op_w(`PSQ_SUB_RETURN, 8'h00)});
         go();
         trace('{10'h000, 10'h001, 10'h002, 10'h155, 10'h156, 10'h2A0, 10'h2A1, 10'h3F0, 10'h3F1, 10'h3F2,
                 10'h2A1, 10'h2A2});
         finals("call and return", r2, r1, 8'h00, r2, 10'h2BB);
         // taken skip then not-taken skip
         prep();
         prog(10'h000, '{op_w(`PSQ_SUB_LOADI, r1), op_w(`PSQ_SUB_STORE, 8'h12), op_w(`PSQ_SUB_LOADI, 8'h00),
                          op_w(`PSQ_SUB_STORE, 8'h20), op_w(`PSQ_SUB_SKIPZ, 8'h20), op_w(`PSQ_SUB_LOADI, r2),
                          op_w(`PSQ_SUB_STORE, 8'h14), op_w(`PSQ_SUB_SKIPZ, 8'h12), op_w(`PSQ_SUB_LOADI, r2),
                          op_w(`PSQ_SUB_STORE, 8'h16)});
         go();
         trace('{10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h005, 10'h006, 10'h007});
         finals("skip", r1, 8'h00, r2, r2, 10'h020);
         // low byte write, indirect access, pointer read, bit ops, reserved read
         prep();
         prog(10'h000, '{br_w(`PSQ_CLS_JUMP, 10'h2F0)});
         prog(10'h2F0, '{op_w(`PSQ_SUB_LOADI, 8'h35), op_w(`PSQ_SUB_STORE, 8'h06)});
         prog(10'h235, '{op_w(`PSQ_SUB_LOADI, 8'h22), op_w(`PSQ_SUB_STORE, 8'h01), op_w(`PSQ_SUB_LOADI, r1),
                          op_w(`PSQ_SUB_STORE, 8'h00), op_w(`PSQ_SUB_STORE, 8'h14), op_w(`PSQ_SUB_LOADI, 8'h00),
                          op_w(`PSQ_SUB_LOAD, 8'h22), op_w(`PSQ_SUB_STORE, 8'h12), op_w(`PSQ_SUB_LOAD, 8'h01),
                          op_w(`PSQ_SUB_STORE, 8'h16), bit_w(1'b1, b1, 8'h14), bit_w(1'b0, b2, 8'h12),
                          op_w(`PSQ_SUB_LOAD, 8'h0C)});
         go();
         trace('{10'h000, 10'h001, 10'h2F0, 10'h2F1, 10'h2F2, 10'h235, 10'h236});
         finals("low byte write", r1 & ~(8'h01 << b2), r1 | (8'h01 << b1), 8'hE2, 8'h00,
                10'h24F);
         // table reads from current and last page, read-only high byte
         prep();
         prog(10'h000, '{br_w(`PSQ_CLS_JUMP, 10'h100)});
         prog({2'h1, p}, '{wc});
         prog({2'h3, p}, '{wl});
         prog(10'h100, '{op_w(`PSQ_SUB_LOADI, p), op_w(`PSQ_SUB_STORE, 8'h07), op_w(`PSQ_SUB_TABC, 8'h20),
                          op_w(`PSQ_SUB_LOAD, 8'h08), op_w(`PSQ_SUB_STORE, 8'h12), op_w(`PSQ_SUB_LOAD, 8'h20),
                          op_w(`PSQ_SUB_STORE, 8'h14), op_w(`PSQ_SUB_TABL, 8'h21), op_w(`PSQ_SUB_LOAD, 8'h21),
                          op_w(`PSQ_SUB_STORE, 8'h16), op_w(`PSQ_SUB_STORE, 8'h08), op_w(`PSQ_SUB_LOAD, 8'h08)});
         go();
         trace('{10'h000, 10'h001, 10'h100, 10'h101, 10'h102, 10'h103, {2'h1, p}, 10'h104, 10'h105, 10'h106,
                 10'h107, 10'h108, {2'h3, p}, 10'h109});
         finals("table read", {2'h0, wc[13:8]}, wc[7:0], wl[7:0], {2'h0, wl[13:8]}, 10'h122);
      end
      stop_test();
   end
endmodule
